/* File: button_cell.sv */
// one front-panel button: status in momentary or alternate mode
// assumes the button level is already debounced and synchronous
`timescale 1ns/100ps
module button_cell
  import switch_button_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pressed, // physical button held down
  input wire button_mode_t mode, // momentary or alternate action
  output logic status_on, // asserted in the on state
  output logic status_off // asserted in the off state
);
  // ----------------------------------------
  // press edge and toggle state
  // ----------------------------------------
  logic pressed_ff; // previous button level
  logic toggle_ff; // alternate-action state
  logic status_ff; // registered status

  // remember last level for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pressed_ff <= 1'b0;
    end else begin
      pressed_ff <= pressed;
    end
  end

  // invert once per press, hold between presses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_ff <= 1'b0;
    end else if (pressed && !pressed_ff) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  // status follows mode; only the physical button feeds it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 1'b0;
    end else if (mode == mode_momentary) begin
      status_ff <= pressed;
    end else begin
      status_ff <= (pressed && !pressed_ff) ? ~toggle_ff : toggle_ff;
    end
  end

  assign status_on = status_ff;
  assign status_off = ~status_ff;
endmodule // button_cell

/* File: event_sink.sv */
// event buffer model standing after the switch block
// assumes one clock and an async active-low reset
`timescale 1ns/100ps
module event_sink (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic stall, // bench holds the buffer full
  input wire logic event_valid, // event offered
  input wire logic [2:0] event_switch, // switch number
  input wire logic event_is_on, // direction
  input wire logic [31:0] event_time, // stamp
  output logic event_ready, // buffer accepts
  output int ev_cnt_ff, // accepted events
  output logic [35:0] last_ev_ff // switch, direction, stamp
);
  // buffer free unless stalled, so slow and prompt answers both occur
  assign event_ready = ~stall;
  // record each accepted event
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_cnt_ff <= 0;
      last_ev_ff <= 36'h0;
    end else if (event_valid && event_ready) begin
      ev_cnt_ff <= ev_cnt_ff + 1;
      last_ev_ff <= {event_switch, event_is_on, event_time};
    end
  end
endmodule // event_sink

/* File: switch_button_pkg.sv */
// package for the command switch and user button block
// shared by the top module and the button cell; no clocking assumptions
package switch_button_pkg;
  localparam int num_switches = 5; // command switches
  localparam int num_buttons = 12; // front-panel buttons
  localparam int sel_width = 4; // width of internal signal select
  localparam int num_int_sigs = 16; // selectable internal signals
  localparam logic [1:0] access_default = 2'h2; // third level is default
  localparam logic [1:0] event_mask_default = 2'h3; // store both on and off
  localparam int mask_on_bit = 0; // mask bit enabling on events
  localparam int mask_off_bit = 1; // mask bit enabling off events
  localparam int ts_width = 32; // time stamp width
  localparam int src_width = 3; // event source field width
  localparam logic [num_switches-1:0] switch_reset_value = 5'h0; // all switches inactive
  typedef enum logic [1:0] {
    level_user,
    level_operator,
    level_configurator,
    level_super
  } access_level_t;
  typedef enum logic [1:0] {
    colour_red,
    colour_orange,
    colour_green,
    colour_off
  } led_colour_t;
  typedef enum logic {
    mode_momentary,
    mode_alternate
  } button_mode_t;
endpackage : switch_button_pkg

/* File: switch_button_props.sv */
// port assertions for the switch and button block
// bound to switch_button_top; one clock, async active-low reset
`timescale 1ns/100ps
module switch_button_props
  import switch_button_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [4:0] panel_cmd_valid, // panel command
  input wire logic [4:0] panel_cmd_state, // panel state
  input wire access_level_t session_level, // session level
  input wire access_level_t required_level, // needed level
  input wire logic [4:0] remote_cmd_valid, // link command
  input wire logic [4:0] remote_cmd_state, // link state
  input wire logic [1:0] event_mask, // store mask
  input wire logic event_ready, // buffer accepts
  input wire logic [4:0] switch_out, // switches
  input wire logic [4:0] cmd_refused, // refusals
  input wire logic event_valid, // event shown
  input wire logic [2:0] event_switch, // switch number
  input wire logic event_is_on, // direction
  input wire logic [31:0] event_time, // stamp
  input wire logic [11:0] button_pressed, // buttons
  input wire logic [11:0] button_alt_mode, // modes
  input wire logic [11:0] button_on, // on status
  input wire logic [11:0] button_off // off status
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_switch_hold: assert property (1 |=> ((switch_out ^ $past(switch_out)) &
    ~$past(remote_cmd_valid) & ~$past(panel_cmd_valid)) == 5'h0) else $error("switch moved");
  chk_remote_apply: assert property (1 |=> ((switch_out ^ $past(remote_cmd_state))
    & $past(remote_cmd_valid)) == 5'h0) else $error("remote command lost");
  chk_panel_apply: assert property (session_level >= required_level |=>
    ((switch_out ^ $past(panel_cmd_state)) & $past(panel_cmd_valid) &
    ~$past(remote_cmd_valid)) == 5'h0) else $error("panel command lost");
  chk_refuse_low: assert property (session_level < required_level && remote_cmd_valid == 5'h0
    |=> cmd_refused == $past(panel_cmd_valid) && $stable(switch_out)) else $error("bad refusal");
  chk_refuse_none: assert property (session_level >= required_level |=> cmd_refused == 5'h0)
    else $error("refused with level");
  chk_event_hold: assert property (event_valid && !event_ready |=> event_valid &&
    $stable(event_switch) && $stable(event_time) && $stable(event_is_on)) else $error("dropped");
  chk_event_mask: assert property (event_valid |-> event_mask[event_is_on ? 0 : 1])
    else $error("masked event shown");
  chk_event_range: assert property (event_valid |-> event_switch < 3'h5)
    else $error("bad switch number");
  chk_button_pair: assert property (button_on == ~button_off)
    else $error("status not complementary");
  chk_button_follow: assert property (1 |=> ((button_on ^ $past(button_pressed)) &
    ~$past(button_alt_mode)) == 12'h0) else $error("momentary status wrong");
  chk_button_toggle: assert property (1 |=> ((button_on ^ $past(button_on)) &
    $past(button_alt_mode)) == ($past(button_pressed) & ~$past(button_pressed, 2) &
    $past(button_alt_mode))) else $error("alternate status wrong");
endmodule // switch_button_props
bind switch_button_top switch_button_props switch_button_props_inst (.ref_clk, .rst_n,
  .panel_cmd_valid, .panel_cmd_state, .session_level, .required_level, .remote_cmd_valid,
  .remote_cmd_state, .event_mask, .event_ready, .switch_out, .cmd_refused, .event_valid,
  .event_switch, .event_is_on, .event_time, .button_pressed, .button_alt_mode, .button_on,
  .button_off);

/* File: switch_button_top.sv */
// command switches with event output and twelve front-panel buttons
// assumes commands and buttons are synchronous single-cycle levels
//
// Notes on behaviour
// - switch holds state until opposite command
// - only panel or remote link command switches
// - panel commands need configured access level
// - five independent latched switch outputs
// - a switch change enabled by event_mask emits a time-stamped event unless one of the same direction is still pending for that switch
// - mask selects on, off, or both stored
// - twelve physical buttons with own status
// - momentary: status active while held
// - alternate: status inverts per press
// - each button LED colour, selectable source
// - buttons changed only by physical buttons
// - complementary on and off status signals
`timescale 1ns/100ps
module switch_button_top
  import switch_button_pkg::*;
(
  input wire logic ref_clk, // 25 mhz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [switch_button_pkg::num_switches-1:0] panel_cmd_valid, // panel command
  input wire logic [switch_button_pkg::num_switches-1:0] panel_cmd_state, // wanted state
  input wire switch_button_pkg::access_level_t session_level, // panel session level
  input wire switch_button_pkg::access_level_t required_level, // configured level
  input wire logic [switch_button_pkg::num_switches-1:0] remote_cmd_valid, // link command
  input wire logic [switch_button_pkg::num_switches-1:0] remote_cmd_state, // wanted state
  input wire logic [1:0] event_mask, // bit0 on events, bit1 off events
  input wire logic [switch_button_pkg::ts_width-1:0] time_stamp, // free-running time
  input wire logic event_ready, // event buffer accepts
  output logic [switch_button_pkg::num_switches-1:0] switch_out, // latched outputs
  output logic [switch_button_pkg::num_switches-1:0] cmd_refused, // refused pulse
  output logic event_valid, // event presented
  output logic [switch_button_pkg::src_width-1:0] event_switch, // switch number
  output logic event_is_on, // direction of change
  output logic [switch_button_pkg::ts_width-1:0] event_time, // stamp of change
  input wire logic [switch_button_pkg::num_buttons-1:0] button_pressed, // button levels
  input wire logic [switch_button_pkg::num_buttons-1:0] button_alt_mode, // 1 alternate
  input wire logic [switch_button_pkg::num_buttons-1:0] led_use_int, // led from internal
  input wire logic [switch_button_pkg::num_buttons*4-1:0] led_int_sel, // internal select
  input wire logic [switch_button_pkg::num_buttons*2-1:0] led_colour_cfg, // colour code
  input wire logic [switch_button_pkg::num_int_sigs-1:0] internal_sigs, // binary signals
  output logic [switch_button_pkg::num_buttons-1:0] button_on, // on status
  output logic [switch_button_pkg::num_buttons-1:0] button_off, // off status
  output logic [switch_button_pkg::num_buttons-1:0] led_red, // red lamp drive
  output logic [switch_button_pkg::num_buttons-1:0] led_green // green lamp drive
);
  import switch_button_pkg::*;

  // ----------------------------------------
  // switch command arbitration
  // ----------------------------------------
  logic [num_switches-1:0] switch_ff; // latched switch states
  logic [num_switches-1:0] refused_ff; // refused command pulses
  logic [num_switches-1:0] nxt_switch; // next switch states
  logic [num_switches-1:0] pend_on_ff; // pending on events
  logic [num_switches-1:0] pend_off_ff; // pending off events
  logic [num_switches-1:0] nxt_pend_on; // next pending on
  logic [num_switches-1:0] nxt_pend_off; // next pending off
  logic panel_ok; // session meets configured level
  logic [num_switches-1:0] rise; // switch turned on
  logic [num_switches-1:0] fall; // switch turned off
  logic [num_switches-1:0] taken; // pending event drained this cycle
  logic taken_on; // drained event direction
  logic [src_width-1:0] pick; // chosen switch index
  logic pick_any; // any pending
  logic pick_on; // chosen event direction
  logic event_valid_ff; // event presented
  logic [src_width-1:0] event_switch_ff; // presented switch
  logic event_on_ff; // presented direction
  logic [ts_width-1:0] event_time_ff; // presented stamp
  logic [ts_width-1:0] stamp_on_ff [num_switches]; // stamp of on change
  logic [ts_width-1:0] stamp_off_ff [num_switches]; // stamp of off change

  assign panel_ok = (session_level >= required_level);

  // remote link wins when both ask in the same cycle; no other source
  always_comb begin
    nxt_switch = switch_ff;
    for (int i = 0; i < num_switches; i++) begin
      if (remote_cmd_valid[i]) begin
        nxt_switch[i] = remote_cmd_state[i];
      end else if (panel_cmd_valid[i] && panel_ok) begin
        nxt_switch[i] = panel_cmd_state[i];
      end
    end
  end

  // hold the latched state until an opposite command arrives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_ff <= switch_reset_value;
    end else begin
      switch_ff <= nxt_switch;
    end
  end

  // flag panel commands refused for access level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_ff <= '0;
    end else begin
      refused_ff <= panel_cmd_valid & ~remote_cmd_valid & {num_switches{~panel_ok}};
    end
  end

  assign rise = nxt_switch & ~switch_ff;
  assign fall = ~nxt_switch & switch_ff;

  // ----------------------------------------
  // event capture and mask
  // ----------------------------------------
  // lowest pending switch goes first, on before off
  always_comb begin
    pick = '0;
    pick_any = 1'b0;
    pick_on = 1'b0;
    for (int i = num_switches - 1; i >= 0; i--) begin
      if (pend_on_ff[i] || pend_off_ff[i]) begin
        pick = src_width'(i);
        pick_any = 1'b1;
        pick_on = pend_on_ff[i];
      end
    end
  end

  assign taken = (pick_any && (!event_valid_ff || event_ready)) ?
                 (num_switches'(1) << pick) : '0;
  assign taken_on = pick_on;

  // new change sets pending; set wins over drain
  always_comb begin
    nxt_pend_on = pend_on_ff;
    nxt_pend_off = pend_off_ff;
    for (int i = 0; i < num_switches; i++) begin
      if (taken[i] && taken_on) begin
        nxt_pend_on[i] = 1'b0;
      end else if (taken[i]) begin
        nxt_pend_off[i] = 1'b0;
      end
      if (rise[i] && event_mask[mask_on_bit]) begin
        nxt_pend_on[i] = 1'b1;
      end
      if (fall[i] && event_mask[mask_off_bit]) begin
        nxt_pend_off[i] = 1'b1;
      end
    end
  end

  // pending flags and time stamps of each change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_on_ff <= '0;
      pend_off_ff <= '0;
      for (int i = 0; i < num_switches; i++) begin
        stamp_on_ff[i] <= '0;
        stamp_off_ff[i] <= '0;
      end
    end else begin
      pend_on_ff <= nxt_pend_on;
      pend_off_ff <= nxt_pend_off;
      for (int i = 0; i < num_switches; i++) begin
        if (rise[i]) begin
          stamp_on_ff[i] <= time_stamp;
        end
        if (fall[i]) begin
          stamp_off_ff[i] <= time_stamp;
        end
      end
    end
  end

  // output stage holds an event until the buffer accepts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_valid_ff <= 1'b0;
      event_switch_ff <= '0;
      event_on_ff <= 1'b0;
      event_time_ff <= '0;
    end else if (!event_valid_ff || event_ready) begin
      event_valid_ff <= pick_any;
      if (pick_any) begin
        event_switch_ff <= pick;
        event_on_ff <= pick_on;
        event_time_ff <= pick_on ? stamp_on_ff[pick] : stamp_off_ff[pick];
      end
    end
  end

  assign switch_out = switch_ff;
  assign cmd_refused = refused_ff;
  assign event_valid = event_valid_ff;
  assign event_switch = event_switch_ff;
  assign event_is_on = event_on_ff;
  assign event_time = event_time_ff;

  // ----------------------------------------
  // buttons and leds
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < num_buttons; b++) begin : g_btn
      logic src; // led source level
      led_colour_t colour; // configured colour
      button_cell u_cell (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pressed(button_pressed[b]),
        .mode(button_alt_mode[b] ? mode_alternate : mode_momentary),
        .status_on(button_on[b]),
        .status_off(button_off[b])
      );
      assign src = led_use_int[b] ? internal_sigs[led_int_sel[b*sel_width +: sel_width]]
                                  : button_on[b];
      assign colour = led_colour_t'(led_colour_cfg[b*2 +: 2]);
      // orange lights both lamps
      assign led_red[b] = src && (colour == colour_red || colour == colour_orange);
      assign led_green[b] = src && (colour == colour_green || colour == colour_orange);
    end
  endgenerate
endmodule // switch_button_top

/* File: switch_button_top_test.sv */
// self-checking bench for switch_button_top with an event buffer model
// assumes a 25 mhz clock and reset held for 20 cycles
`timescale 1ns/100ps
module switch_button_top_test;
  import switch_button_pkg::*;
  logic ref_clk = 1'b0; // clock
  logic rst_n = 1'b0; // reset
  logic [4:0] panel_cmd_valid = 5'h0, panel_cmd_state = 5'h0; // panel side
  logic [4:0] remote_cmd_valid = 5'h0, remote_cmd_state = 5'h0; // link side
  access_level_t session_level = level_user, required_level = level_configurator; // levels
  logic [1:0] event_mask = 2'h3; // store both
  logic [31:0] time_stamp = 32'h0, exp_t; // free-running time
  logic event_ready, stall = 1'b0, event_valid, event_is_on; // event handshake
  logic [2:0] event_switch; // event switch
  logic [31:0] event_time; // event stamp
  logic [4:0] switch_out, cmd_refused; // outputs
  logic [11:0] button_pressed = 12'h0, button_alt_mode = 12'h0, led_use_int = 12'h0;
  logic [47:0] led_int_sel = 48'h0; // led selects
  logic [23:0] led_colour_cfg = 24'h0; // led colours
  logic [15:0] internal_sigs = 16'h0; // internal signals
  logic [11:0] button_on, button_off, led_red, led_green; // button outputs
  int ev_cnt, error_cnt = 0, cmp_count = 0; // counters
  logic [35:0] last_ev; // last stored event
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) time_stamp <= time_stamp + 32'h1;
  switch_button_top switch_button_top_inst (.ref_clk, .rst_n, .panel_cmd_valid,
    .panel_cmd_state, .session_level, .required_level, .remote_cmd_valid, .remote_cmd_state,
    .event_mask, .time_stamp, .event_ready, .switch_out, .cmd_refused, .event_valid,
    .event_switch, .event_is_on, .event_time, .button_pressed, .button_alt_mode, .led_use_int,
    .led_int_sel, .led_colour_cfg, .internal_sigs, .button_on, .button_off, .led_red,
    .led_green);
  event_sink event_sink_inst (.ref_clk, .rst_n, .stall, .event_valid, .event_switch,
    .event_is_on, .event_time, .event_ready, .ev_cnt_ff(ev_cnt), .last_ev_ff(last_ev));
  // compare one value, count it
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle command from the link (rem=1) or the panel; stamp noted
  task automatic send(input logic rem, input int i, input logic st);
    @(posedge ref_clk);
    if (rem) begin
      remote_cmd_valid[i] <= 1'b1;
      remote_cmd_state[i] <= st;
    end else begin
      panel_cmd_valid[i] <= 1'b1;
      panel_cmd_state[i] <= st;
    end
    #1 exp_t = time_stamp;
    @(posedge ref_clk);
    remote_cmd_valid <= 5'h0;
    panel_cmd_valid <= 5'h0;
    #1;
  endtask
  // let events drain, then compare the stored count
  task automatic wait_ev(input int n);
    repeat (8) @(posedge ref_clk);
    for (int k = 0; k < 30 && ev_cnt < n; k++) @(posedge ref_clk);
    #1 check(ev_cnt, n);
  endtask
  // drive button levels, left held afterwards, and compare status one cycle later
  task automatic btn(input logic [11:0] p, input logic [11:0] e);
    @(posedge ref_clk);
    button_pressed <= p;
    @(posedge ref_clk);
    #1 check(button_on, e);
  endtask
  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 check({button_off, switch_out}, {12'hfff, 5'h0});
    @(posedge ref_clk);
    stall <= 1'b1;
    send(1'b1, 2, 1'b1);
    check(switch_out, 5'h04);
    repeat (5) @(posedge ref_clk);
    stall <= 1'b0;
    wait_ev(1);
    check(last_ev, {3'h2, 1'b1, exp_t});
    for (int i = 0; i < 5; i++) begin
      send(1'b1, i, 1'b1);
      check(switch_out[i], 1'b1);
      send(1'b1, i, 1'b0);
    end
    wait_ev(10);
    check(last_ev, {3'h4, 1'b0, exp_t});
    $display("switch and event test done");
    @(posedge ref_clk);
    event_mask <= 2'h1;
    send(1'b1, 0, 1'b1);
    send(1'b1, 0, 1'b0);
    wait_ev(11);
    check(last_ev[35:32], {3'h0, 1'b1});
    @(posedge ref_clk);
    event_mask <= 2'h2;
    send(1'b1, 1, 1'b1);
    send(1'b1, 1, 1'b0);
    wait_ev(12);
    check(last_ev[35:32], {3'h1, 1'b0});
    @(posedge ref_clk);
    event_mask <= 2'h3;
    for (int lv = 0; lv < 4; lv++) begin
      @(posedge ref_clk);
      session_level <= access_level_t'(lv);
      send(1'b0, 3, 1'b1);
      check({cmd_refused[3], switch_out[3]}, {lv < 2, lv >= 2});
      send(1'b1, 3, 1'b0);
    end
    wait_ev(16);
    $display("mask and access test done");
    @(posedge ref_clk);
    button_alt_mode <= 12'h0f0;
    btn(12'hfff, 12'hfff);
    btn(12'h000, 12'h0f0);
    btn(12'hfff, 12'hf0f);
    btn(12'h000, 12'h000);
    send(1'b1, 0, 1'b1);
    check({button_on, switch_out}, {12'h0, 5'h01});
    @(posedge ref_clk);
    led_use_int <= 12'hfff;
    led_int_sel <= {12{4'h5}};
    internal_sigs <= 16'h0020;
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk);
      led_colour_cfg <= {12{c[1:0]}};
      @(posedge ref_clk);
      #1 check({led_red, led_green}, {{12{c < 2}}, {12{c == 1 || c == 2}}});
    end
    // led taken from the button's own status
    @(posedge ref_clk);
    led_use_int <= 12'h000;
    led_colour_cfg <= 24'h0;
    btn(12'h001, 12'h001);
    check(led_red, 12'h001);
    check(button_off, 12'hffe);
    $display("button and led test done");
    give_verdict();
  end
endmodule // switch_button_top_test
